// >>> pmt_pkg.sv
// Package of constants for the program memory and table read block.
package pmt_pkg;
  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int PMT_WORDS      = 4096;
  localparam int PMT_ADDR_W     = 12;
  localparam int PMT_WORD_W     = 16;
  localparam int PMT_PAGE_W     = 8;
  localparam int PMT_DMEM_W     = 10;
  localparam int PMT_SECTOR_LSB = 8;

  // ==========================================================================
  // Reset values and timing
  // ==========================================================================
  localparam logic [11:0] PMT_RESET_VECTOR = 12'h000;
  localparam logic [3:0]  PMT_LAST_PAGE    = 4'hF;
  localparam logic [7:0]  PMT_TABLE_HIGH_LATCH_RESET   = 8'h00;
  localparam int          PMT_TABLE_CYCLES = 2;

  // ==========================================================================
  // Serial programming commands, one bit each
  // ==========================================================================
  localparam logic [7:0] PMT_CMD_WRITE = 8'h01;
  localparam logic [7:0] PMT_CMD_READ  = 8'h02;

  typedef enum logic [1:0] {
    PMT_T_IDLE = 2'b00,
    PMT_T_READ = 2'b01,
    PMT_T_DONE = 2'b11
  } pmt_tstate_e;
endpackage : pmt_pkg

// >>> pmt_serial_port.sv
// Two-wire serial programming port for the program store.
`timescale 1ns/1ps
module pmt_serial_port
  import pmt_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  sclk_i,
  input  wire logic                  sdat_i,
  output logic                       sdat_o,
  output logic                       sdat_oe,
  output logic                       wr_en,
  output logic [PMT_ADDR_W-1:0]      wr_addr,
  output logic [PMT_WORD_W-1:0]      wr_data,
  output logic [PMT_ADDR_W-1:0]      rd_addr,
  input  wire logic [PMT_WORD_W-1:0] rd_data
);
  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [1:0] ck_sync_q, dt_sync_q;
  logic       ck_prev_q;
  logic       rise, fall;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ck_sync_q <= 2'b00;
      dt_sync_q <= 2'b00;
      ck_prev_q <= 1'b0;
    end else if (ce) begin
      ck_sync_q <= {ck_sync_q[0], sclk_i};
      dt_sync_q <= {dt_sync_q[0], sdat_i};
      ck_prev_q <= ck_sync_q[1];
    end
  end
  assign rise = ck_sync_q[1] & ~ck_prev_q;
  assign fall = ~ck_sync_q[1] & ck_prev_q;

  // ==========================================================================
  // Frame: 8 command bits, 12 address bits, then 16 data bits in or out.
  // Data moves MSB first on the rising clock; reads drive on the falling edge.
  // ==========================================================================
  localparam int FRAME = 36;
  logic [5:0]            cnt_q, cnt_d;
  logic [35:0]           sh_q, sh_d;
  logic [PMT_WORD_W-1:0] out_q, out_d;
  logic                  oe_q, oe_d, do_q, do_d, we_q, we_d;

  always_comb begin
    cnt_d = cnt_q;
    sh_d  = sh_q;
    out_d = out_q;
    oe_d  = oe_q;
    do_d  = do_q;
    we_d  = 1'b0;
    if (rise) begin
      sh_d  = {sh_q[34:0], dt_sync_q[1]};
      cnt_d = cnt_q + 6'd1;
      // The word is not taken here: the store answers the full address only
      // one cycle after the last address bit, well before the next fall.
      if (cnt_d == 6'd20 && sh_d[19:12] == PMT_CMD_READ) begin
        oe_d  = 1'b1;
      end
      if (cnt_d == 6'(FRAME)) begin
        cnt_d = 6'd0;
        oe_d  = 1'b0;
        we_d  = (sh_d[35:28] == PMT_CMD_WRITE);
      end
    end else if (fall && oe_q) begin
      if (cnt_q == 6'd20) begin
        do_d  = rd_data[PMT_WORD_W-1];
        out_d = {rd_data[PMT_WORD_W-2:0], 1'b0};
      end else begin
        do_d  = out_q[PMT_WORD_W-1];
        out_d = {out_q[PMT_WORD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 6'd0;
      sh_q  <= 36'h0_0000_0000;
      out_q <= 16'h0000;
      oe_q  <= 1'b0;
      do_q  <= 1'b0;
      we_q  <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      out_q <= out_d;
      oe_q  <= oe_d;
      do_q  <= do_d;
      we_q  <= we_d;
    end
  end

  assign sdat_o  = do_q;
  assign sdat_oe = oe_q;
  assign wr_en   = we_q;
  assign wr_addr = sh_q[27:16];
  assign wr_data = sh_q[15:0];
  assign rd_addr = sh_q[11:0];
endmodule : pmt_serial_port

// >>> pmt_program_memory.sv
// Program store with instruction fetch, table read unit and serial programming.
`timescale 1ns/1ps
module pmt_program_memory
  import pmt_pkg::*;
#(
  parameter int WORD_W = PMT_WORD_W,
  parameter int ADDR_W = PMT_ADDR_W
)
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [ADDR_W-1:0]     pc,
  input  wire logic                  fetch_en,
  output logic [WORD_W-1:0]          instr_word,
  output logic [ADDR_W-1:0]          fetch_addr,
  input  wire logic                  table_read_op,
  input  wire logic                  ext_table_read_op,
  input  wire logic                  last_page_sel,
  input  wire logic [PMT_DMEM_W-1:0] table_dest,
  input  wire logic [7:0]            table_ptr_low,
  input  wire logic [7:0]            table_ptr_high,
  output logic                       table_busy,
  output logic                       dmem_wr_en,
  output logic [PMT_DMEM_W-1:0]      dmem_wr_addr,
  output logic [7:0]                 dmem_wr_data,
  input  wire logic                  table_high_wr,
  input  wire logic [7:0]            table_high_wdata,
  output logic [7:0]                 table_high_latch,
  input  wire logic                  debug_serial_clock,
  input  wire logic                  debug_serial_data_i,
  output logic                       debug_serial_data_o,
  output logic                       debug_serial_data_oe
);
  // ==========================================================================
  // Program store
  // ==========================================================================
  logic [WORD_W-1:0] mem [PMT_WORDS];
  logic              pw_en;
  logic [ADDR_W-1:0] pw_addr, pr_addr;
  logic [WORD_W-1:0] pw_data;
  logic [WORD_W-1:0] prog_rd_q;
  logic              so_w, soe_w;

  // The debug pins double as programming pins, so one port serves both.
  pmt_serial_port u_serial (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .sclk_i  (debug_serial_clock),
    .sdat_i  (debug_serial_data_i),
    .sdat_o  (so_w),
    .sdat_oe (soe_w),
    .wr_en   (pw_en),
    .wr_addr (pw_addr),
    .wr_data (pw_data),
    .rd_addr (pr_addr),
    .rd_data (prog_rd_q)
  );

  // ==========================================================================
  // Table read sequencer
  // ==========================================================================
  // The stored word is read in the middle cycle and handed out in the last, so
  // the store sees its address a full cycle before it must answer.
  pmt_tstate_e           st_q, st_d;
  logic [ADDR_W-1:0]     taddr_q, taddr_d;
  logic [PMT_DMEM_W-1:0] tdst_q, tdst_d;
  logic [7:0]            tbh_q, tbh_d;
  logic                  dwe_d, dwe_q;
  logic [7:0]            dwd_d, dwd_q;
  logic [WORD_W-1:0]     tword_q;
  logic [ADDR_W-1:0]     fa_q, fa_d;
  logic [WORD_W-1:0]     iw_q;
  logic                  busy_d, busy_q;

  always_comb begin
    st_d    = st_q;
    taddr_d = taddr_q;
    tdst_d  = tdst_q;
    dwe_d   = 1'b0;
    dwd_d   = dwd_q;
    case (st_q)
      PMT_T_IDLE: begin
        // Requests that arrive while a read is in flight are dropped without
        // any sign, so the core must wait until the previous read completes.
        if (table_read_op || ext_table_read_op) begin
          st_d = PMT_T_READ;
          // Pointer is only sampled, never written back.
          if (last_page_sel) begin
            taddr_d = ADDR_W'({PMT_LAST_PAGE, table_ptr_low});
          end else begin
            taddr_d = ADDR_W'({table_ptr_high, table_ptr_low});
          end
          // Standard forms can only name sector 0.
          if (ext_table_read_op) begin
            tdst_d = table_dest;
          end else begin
            tdst_d = {2'b00, table_dest[PMT_SECTOR_LSB-1:0]};
          end
        end
      end
      PMT_T_READ: begin
        st_d  = PMT_T_DONE;
      end
      PMT_T_DONE: begin
        // Second cycle closes the instruction.
        st_d  = PMT_T_IDLE;
        dwe_d = 1'b1;
        dwd_d = tword_q[7:0];
      end
      default: st_d = PMT_T_IDLE;
    endcase
    // Busy is taken from the next state so that the output stands in a flop.
    busy_d = (st_d != PMT_T_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q    <= PMT_T_IDLE;
      taddr_q <= PMT_RESET_VECTOR;
      tdst_q  <= '0;
      dwe_q   <= 1'b0;
      dwd_q   <= 8'h00;
      busy_q  <= 1'b0;
    end else if (ce) begin
      st_q    <= st_d;
      taddr_q <= taddr_d;
      tdst_q  <= tdst_d;
      dwe_q   <= dwe_d;
      dwd_q   <= dwd_d;
      busy_q  <= busy_d;
    end
  end

  // ==========================================================================
  // Table-high latch
  // ==========================================================================
  // A completing read wins over a software write in the same cycle, so the
  // latch holds the high byte of the word whose low byte was last stored, until software writes it.
  always_comb begin
    tbh_d = tbh_q;
    if (st_q == PMT_T_DONE) begin
      tbh_d = 8'(tword_q[WORD_W-1:8]);
    end else if (table_high_wr) begin
      tbh_d = table_high_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tbh_q <= PMT_TABLE_HIGH_LATCH_RESET;
    end else if (ce) begin
      tbh_q <= tbh_d;
    end
  end

  // ==========================================================================
  // Instruction fetch
  // ==========================================================================
  // The word is read with the next address, so it stands together with
  // fetch_addr one cycle after the request, as a synchronous store allows.
  always_comb begin
    fa_d = fa_q;
    if (fetch_en) begin
      fa_d = pc;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fa_q <= PMT_RESET_VECTOR;
    end else if (ce) begin
      fa_q <= fa_d;
    end
  end

  // ==========================================================================
  // Memory ports: no reset on the array so it maps onto block RAM.
  // ==========================================================================
  // A programming write and a fetch of the same word in one cycle return the
  // old word; the core is expected to stand still while it is programmed.
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (pw_en) begin
        mem[pw_addr] <= pw_data;
      end
      iw_q      <= mem[fa_d];
      tword_q   <= mem[taddr_q];
      prog_rd_q <= mem[pr_addr];
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign instr_word           = iw_q;
  assign fetch_addr           = fa_q;
  assign table_busy           = busy_q;
  assign dmem_wr_en           = dwe_q;
  assign dmem_wr_addr         = tdst_q;
  assign dmem_wr_data         = dwd_q;
  assign table_high_latch     = tbh_q;
  assign debug_serial_data_o  = so_w;
  assign debug_serial_data_oe = soe_w;
endmodule : pmt_program_memory

// >>> pmt_program_memory_asserts.sv
// Checker for fetch, table read and table-high latch behaviour.
`timescale 1ns/1ps
module pmt_checker
  import pmt_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic [PMT_ADDR_W-1:0] pc,
  input wire logic                  fetch_en,
  input wire logic [PMT_ADDR_W-1:0] fetch_addr,
  input wire logic                  table_read_op,
  input wire logic                  ext_table_read_op,
  input wire logic [PMT_DMEM_W-1:0] table_dest,
  input wire logic                  table_busy,
  input wire logic                  dmem_wr_en,
  input wire logic [PMT_DMEM_W-1:0] dmem_wr_addr,
  input wire logic                  table_high_wr,
  input wire logic [7:0]            table_high_wdata,
  input wire logic [7:0]            table_high_latch
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    ce && (table_read_op || ext_table_read_op) && !table_busy;
  endsequence
  sequence s_done;
    table_busy [*2] ##1 (!table_busy && dmem_wr_en);
  endsequence
  property p_cycles; s_take |=> s_done; endproperty
  a_cycles: assert property (p_cycles) else $error("table read length wrong");
  property p_std; s_take ##0 !ext_table_read_op |-> ##3 dmem_wr_addr[9:8] == 2'b00; endproperty
  a_std: assert property (p_std) else $error("standard read left sector 0");
  property p_ext; s_take ##0 ext_table_read_op |-> ##3 dmem_wr_addr == $past(table_dest, 3); endproperty
  a_ext: assert property (p_ext) else $error("extended read address wrong");
  property p_lo; s_take |-> ##3 dmem_wr_addr[7:0] == $past(table_dest[7:0], 3); endproperty
  a_lo: assert property (p_lo) else $error("destination offset wrong");
  property p_src; dmem_wr_en |-> $past(table_busy) && !table_busy; endproperty
  a_src: assert property (p_src) else $error("write without busy phase");
  property p_hold; $changed(table_high_latch) |-> $past(table_high_wr) || dmem_wr_en; endproperty
  a_hold: assert property (p_hold) else $error("latch changed without cause");
  property p_sw; ce && table_high_wr && !table_busy |=> table_high_latch == $past(table_high_wdata); endproperty
  a_sw: assert property (p_sw) else $error("software latch write lost");
  property p_fetch; ce && fetch_en |=> fetch_addr == $past(pc); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  property p_reset;
    disable iff (1'b0) rst && ce |=> fetch_addr == PMT_RESET_VECTOR && table_high_latch == 8'h00 && !table_busy;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : pmt_checker

bind pmt_program_memory pmt_checker chk_u (.mclk(mclk), .rst(rst), .ce(ce), .pc(pc), .fetch_en(fetch_en),
  .fetch_addr(fetch_addr), .table_read_op(table_read_op), .ext_table_read_op(ext_table_read_op),
  .table_dest(table_dest), .table_busy(table_busy), .dmem_wr_en(dmem_wr_en), .dmem_wr_addr(dmem_wr_addr),
  .table_high_wr(table_high_wr), .table_high_wdata(table_high_wdata), .table_high_latch(table_high_latch));

// >>> pmt_prog_model.sv
// Behavioural model of the external programmer on the two-wire serial port.
`timescale 1ns/1ps
module pmt_prog_model
  import pmt_pkg::*;
(
  input  wire logic mclk,
  input  wire logic dev_o,
  input  wire logic dev_oe,
  output logic      sck,
  output logic      line
);
  logic drv = 1'b0;
  logic bit_q = 1'b0;
  // A released line shows the inverse of its last level, so stale data never passes as good.
  assign line = dev_oe ? dev_o : (drv ? bit_q : ~bit_q);
  initial sck = 1'b0;
  // The clock stands low between frames; each half period is 10 core cycles.
  task automatic frame(input logic [7:0] cmd, input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] q);
    logic [35:0] f;
    f = {cmd, a, d};
    q = 16'h0000;
    for (int i = 35; i >= 0; i--) begin
      drv <= !(cmd == PMT_CMD_READ && i < 16);
      bit_q <= f[i];
      repeat (10) @(posedge mclk);
      sck <= 1'b1;
      q = {q[14:0], line};
      repeat (10) @(posedge mclk);
      sck <= 1'b0;
    end
    drv <= 1'b0;
    @(posedge mclk);
  endtask : frame
endmodule : pmt_prog_model

// >>> program_memory_table_read_tb.sv
// Self-checking bench for the program store and table read block.
`timescale 1ns/1ps
module program_memory_table_read_tb
  import pmt_pkg::*;
();
  logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1, fetch_en = 1'b0, table_read_op = 1'b0;
  logic        ext_table_read_op = 1'b0, last_page_sel = 1'b0, table_high_wr = 1'b0;
  logic [11:0] pc = 12'h000;
  logic [9:0]  table_dest = 10'h000;
  logic [7:0]  table_ptr_low = 8'h00, table_ptr_high = 8'h00, table_high_wdata = 8'h00;
  logic [15:0] instr_word, q;
  logic [11:0] fetch_addr;
  logic [9:0]  dmem_wr_addr;
  logic [7:0]  dmem_wr_data, table_high_latch;
  logic        table_busy, dmem_wr_en, sck, sda, dbg_o, dbg_oe;
  int          err_total = 0, compares = 0;
  localparam logic [11:0] AD [4] = '{12'h000, 12'h306, 12'h305, 12'hF06};
  localparam logic [15:0] WD [4] = '{16'h1234, 16'hBEEF, 16'h5A0F, 16'h00C1};

  always #2 mclk = ~mclk;

  pmt_program_memory dut_u (.mclk(mclk), .rst(rst), .ce(ce), .pc(pc), .fetch_en(fetch_en),
    .instr_word(instr_word), .fetch_addr(fetch_addr), .table_read_op(table_read_op),
    .ext_table_read_op(ext_table_read_op), .last_page_sel(last_page_sel), .table_dest(table_dest),
    .table_ptr_low(table_ptr_low), .table_ptr_high(table_ptr_high), .table_busy(table_busy),
    .dmem_wr_en(dmem_wr_en), .dmem_wr_addr(dmem_wr_addr), .dmem_wr_data(dmem_wr_data),
    .table_high_wr(table_high_wr), .table_high_wdata(table_high_wdata), .table_high_latch(table_high_latch),
    .debug_serial_clock(sck), .debug_serial_data_i(sda), .debug_serial_data_o(dbg_o),
    .debug_serial_data_oe(dbg_oe));
  pmt_prog_model prog_u (.mclk(mclk), .dev_o(dbg_o), .dev_oe(dbg_oe), .sck(sck), .line(sda));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic t_fetch(input logic [11:0] a, input logic [15:0] w);
    fetch_en <= 1'b1;
    pc <= a;
    @(posedge mclk);
    fetch_en <= 1'b0;
    @(negedge mclk);
    chk({4'h0, fetch_addr, instr_word}, {4'h0, a, w});
    @(posedge mclk);
  endtask : t_fetch

  // With junk set the request is held one more edge, while busy, with another pointer.
  task automatic tread(input logic x, input logic lp, input logic junk, input logic [7:0] ph,
                       input logic [7:0] pl, input logic [9:0] dst, input logic [15:0] w);
    int n;
    table_read_op <= ~x;
    ext_table_read_op <= x;
    last_page_sel <= lp;
    table_ptr_high <= ph;
    table_ptr_low <= pl;
    table_dest <= dst;
    @(posedge mclk);
    n = int'(junk);
    if (junk) begin
      table_ptr_low <= pl + 8'h01;
      @(posedge mclk);
    end
    table_read_op <= 1'b0;
    ext_table_read_op <= 1'b0;
    do begin
      @(negedge mclk);
      n++;
    end while (dmem_wr_en !== 1'b1 && n < 8);
    chk(32'(n), 32'h0000_0003);
    chk({22'h00_0000, dmem_wr_addr}, {22'h00_0000, x ? dst : {2'b00, dst[7:0]}});
    chk({16'h0000, table_high_latch, dmem_wr_data}, {16'h0000, w});
    repeat (2) begin
      @(negedge mclk);
      chk({31'h0000_0000, dmem_wr_en}, 32'h0000_0000);
    end
    @(posedge mclk);
  endtask : tread

  // Software writes the latch only while no table read is in flight.
  task automatic t_latch();
    table_high_wr <= 1'b1;
    table_high_wdata <= 8'h96;
    @(posedge mclk);
    table_high_wr <= 1'b0;
    @(negedge mclk);
    chk({24'h00_0000, table_high_latch}, 32'h0000_0096);
    @(posedge mclk);
  endtask : t_latch

  // With the clock enable low a fetch request must leave fetch_addr and instr_word as they were.
  task automatic t_freeze();
    ce <= 1'b0;
    fetch_en <= 1'b1;
    pc <= AD[2];
    @(posedge mclk);
    ce <= 1'b1;
    fetch_en <= 1'b0;
    @(negedge mclk);
    chk({4'h0, fetch_addr, instr_word}, {4'h0, AD[3], WD[3]});
    @(posedge mclk);
  endtask : t_freeze

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({table_high_latch, 3'h0, table_busy, fetch_addr}, 24'h00_0000);
    @(posedge mclk);
    for (int i = 0; i < 4; i++) prog_u.frame(PMT_CMD_WRITE, AD[i], WD[i], q);
    prog_u.frame(PMT_CMD_READ, AD[1], 16'h0000, q);
    chk({16'h0000, q}, {16'h0000, WD[1]});
    for (int i = 0; i < 4; i++) t_fetch(AD[i], WD[i]);
    t_freeze();
    t_latch();
    tread(1'b0, 1'b0, 1'b0, 8'h03, 8'h06, 10'h345, WD[1]);
    tread(1'b1, 1'b0, 1'b1, 8'h03, 8'h05, 10'h2C7, WD[2]);
    tread(1'b0, 1'b1, 1'b0, 8'h03, 8'h06, 10'h012, WD[3]);
    tread(1'b1, 1'b1, 1'b0, 8'h00, 8'h06, 10'h3FF, WD[3]);
    tread(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 10'h100, WD[0]);
    test_done();
  end

  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule : program_memory_table_read_tb
